// >>> pkg/swc_pkg.sv
/*
 * Constants, register map and carrier types of the sleep and wake-up controller.
 * Assumes a 50 MHz system clock and a classic Wishbone master with 32-bit data.
 */
package swc_pkg;
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned TOSC_NS = 20;
	localparam int unsigned OST_PERIODS = 1024;
	localparam int unsigned OST_CYC = (OST_PERIODS * TOSC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned WDT_PERIOD_MS = 18;
	localparam int unsigned WDT_PERIOD_CYC = (WDT_PERIOD_MS * 1000000) / CLK_PERIOD_NS;
	localparam int unsigned WDT_CNT_W = 20;
	localparam int unsigned OST_CNT_W = 11;
	localparam logic [12:0] IRQ_VECTOR = 13'h0004;
	localparam int unsigned NUM_IRQ = 3;
	localparam int unsigned NUM_IO = 8;
	localparam logic [7:0] REG_CTRL_ADR = 8'h00;
	localparam logic [7:0] REG_STAT_ADR = 8'h04;
	localparam int unsigned CTRL_WDT_EN_BIT = 0;
	localparam int unsigned CTRL_XTAL_BIT = 1;
	localparam int unsigned CTRL_IRQEN_LSB = 2;
	localparam int unsigned CTRL_W = 5;
	localparam logic [4:0] CTRL_RST_VAL = 5'h03;
	localparam int unsigned STAT_PD_BIT = 0;
	localparam int unsigned STAT_TO_BIT = 1;
	localparam int unsigned STAT_ASLEEP_BIT = 2;
	localparam int unsigned STAT_WK_WDT_BIT = 3;
	localparam int unsigned STAT_WK_IRQ_BIT = 4;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} swc_wb_req_t;

	typedef struct packed {
		logic [7:0] drv;
		logic [7:0] oe;
	} swc_io_t;

	typedef enum logic [5:0] {
		S_RUN = 6'b000001,
		S_SLEEP = 6'b000010,
		S_OST = 6'b000100,
		S_RESUME = 6'b001000,
		S_DUMMY1 = 6'b010000,
		S_DUMMY2 = 6'b100000
	} swc_state_t;
endpackage

// >>> rtl/swc_watchdog.sv
/*
 * Watchdog counter for the sleep controller.
 * Assumes the system clock keeps running while the core clock is stopped.
 */
`timescale 1ns/1ps
module swc_watchdog #(
	parameter int unsigned PERIOD_CYC = swc_pkg::WDT_PERIOD_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic enable,
	input wire logic clear,
	output logic timeout
);
	import swc_pkg::*;

	logic [WDT_CNT_W-1:0] cnt_q;
	logic [WDT_CNT_W-1:0] cnt_d;
	logic timeout_q;
	wire logic at_end = (cnt_q == WDT_CNT_W'(PERIOD_CYC - 1));

	// A clear restarts the count but the watchdog keeps running afterwards.
	assign cnt_d = (clear || !enable || at_end) ? '0 : cnt_q + WDT_CNT_W'(1);
	assign timeout = timeout_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q <= '0;
			timeout_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			timeout_q <= enable && !clear && at_end;
		end
	end
endmodule

// >>> rtl/swc_sleep_ctrl.sv
/*
 * Sleep entry and wake-up controller with a Wishbone register slave.
 * Assumes the core pulses SLEEP_EXEC and WDT_CLR_EXEC for one cycle per executed
 * instruction and honours CORE_RUN as its clock enable.
 */
`timescale 1ns/1ps
module swc_sleep_ctrl #(
	parameter int unsigned WDT_CYC = swc_pkg::WDT_PERIOD_CYC
) (
	input wire logic CLK,
	input wire logic RST,
	input swc_pkg::swc_wb_req_t WB_REQ,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK,
	input wire logic SLEEP_EXEC,
	input wire logic WDT_CLR_EXEC,
	input wire logic EXT_RESET_REQ,
	input wire logic GLOBAL_IRQ_ENABLE,
	input wire logic [2:0] IRQ_FLAG,
	input swc_pkg::swc_io_t IO_CORE,
	output swc_pkg::swc_io_t IO_PINS,
	output logic OSC_DRV_EN,
	output logic CORE_RUN,
	output logic PREFETCH_NEXT,
	output logic EXEC_FOLLOW,
	output logic DUMMY_CYCLE,
	output logic VECTOR_LOAD,
	output logic [12:0] VECTOR_ADDR,
	output logic DEVICE_RESET
);
	import swc_pkg::*;

	function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] off);
		reg_hit = (adr == off);
	endfunction

	swc_state_t state_q;
	swc_state_t state_d;
	logic [CTRL_W-1:0] ctrl_q;
	logic pd_q;
	logic to_q;
	logic wk_wdt_q;
	logic wk_irq_q;
	logic vec_q;
	logic [OST_CNT_W-1:0] ost_q;
	logic ack_q;
	logic [31:0] dat_q;
	swc_io_t io_q;
	logic osc_q;
	logic run_q;
	logic pref_q;
	logic follow_q;
	logic dummy_q;
	logic vload_q;
	logic rst_out_q;
	logic wdt_to;

	wire logic wdt_en = ctrl_q[CTRL_WDT_EN_BIT];
	wire logic xtal = ctrl_q[CTRL_XTAL_BIT];
	wire logic [NUM_IRQ-1:0] irq_en = ctrl_q[CTRL_IRQEN_LSB +: NUM_IRQ];
	wire logic irq_pend = |(IRQ_FLAG & irq_en);
	wire logic st_run = state_q[0];
	wire logic st_sleep = state_q[1];
	wire logic st_ost = state_q[2];
	wire logic st_resume = state_q[3];
	wire logic st_dummy2 = state_q[5];
	wire logic wdt_rst = st_run && wdt_to;
	wire logic sleep_entry = st_run && SLEEP_EXEC && !irq_pend && !wdt_rst;
	wire logic rst_wake = st_sleep && EXT_RESET_REQ;
	wire logic wdt_wake = st_sleep && !EXT_RESET_REQ && wdt_to;
	wire logic irq_wake = st_sleep && !EXT_RESET_REQ && !wdt_to && irq_pend;
	wire logic ost_done = (ost_q == OST_CNT_W'(OST_CYC - 1));
	wire logic wb_req = WB_REQ.cyc && WB_REQ.stb;
	wire logic wb_wr = wb_req && WB_REQ.we && ack_q && WB_REQ.sel[0];
	wire logic hit_ctrl = reg_hit(WB_REQ.adr, REG_CTRL_ADR);
	wire logic hit_stat = reg_hit(WB_REQ.adr, REG_STAT_ADR);
	wire logic [31:0] rd_ctrl = {{(32 - CTRL_W){1'b0}}, ctrl_q};
	wire logic [31:0] rd_stat = {27'h0, wk_irq_q, wk_wdt_q, !st_run, to_q, pd_q};
	wire logic [31:0] rd_mux = hit_ctrl ? rd_ctrl : (hit_stat ? rd_stat : 32'h0);
	wire logic wdt_clear = WDT_CLR_EXEC || sleep_entry;

	swc_watchdog #(
		.PERIOD_CYC(WDT_CYC)
	) u_wdt (
		.clk(CLK),
		.rst(RST),
		.enable(wdt_en),
		.clear(wdt_clear),
		.timeout(wdt_to)
	);

	always_comb begin
		state_d = state_q;
		case (state_q)
			S_RUN: begin
				if (sleep_entry)
					state_d = S_SLEEP;
			end
			S_SLEEP: begin
				if (rst_wake)
					state_d = S_RUN;
				else if (wdt_wake || irq_wake)
					state_d = xtal ? S_OST : S_RESUME;
			end
			S_OST: begin
				if (ost_done)
					state_d = S_RESUME;
			end
			S_RESUME: begin
				state_d = vec_q ? S_DUMMY1 : S_RUN;
			end
			S_DUMMY1: begin
				state_d = S_DUMMY2;
			end
			S_DUMMY2: begin
				state_d = S_RUN;
			end
			default: begin
				state_d = S_RUN;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST)
			state_q <= S_RUN;
		else
			state_q <= state_d;
	end

	// Status flags. Entry sets the timeout flag; any watchdog timeout clears it.
	always_ff @(posedge CLK) begin
		if (RST) begin
			pd_q <= 1'b1;
			to_q <= 1'b1;
		end else begin
			if (sleep_entry) begin
				pd_q <= 1'b0;
				to_q <= 1'b1;
			end else if (wdt_to) begin
				to_q <= 1'b0;
			end
		end
	end

	// Wake cause and vector decision are taken when the sleep ends.
	always_ff @(posedge CLK) begin
		if (RST) begin
			wk_wdt_q <= 1'b0;
			wk_irq_q <= 1'b0;
			vec_q <= 1'b0;
		end else if (st_sleep && (wdt_wake || irq_wake || rst_wake)) begin
			wk_wdt_q <= wdt_wake;
			wk_irq_q <= irq_wake;
			vec_q <= irq_wake && GLOBAL_IRQ_ENABLE;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST || !st_ost)
			ost_q <= '0;
		else
			ost_q <= ost_q + OST_CNT_W'(1);
	end

	// Registered outputs follow the next state so they line up with state_q.
	always_ff @(posedge CLK) begin
		if (RST) begin
			osc_q <= 1'b1;
			run_q <= 1'b1;
			pref_q <= 1'b0;
			follow_q <= 1'b0;
			dummy_q <= 1'b0;
			vload_q <= 1'b0;
			rst_out_q <= 1'b0;
		end else begin
			osc_q <= !state_d[1];
			run_q <= state_d[0] || state_d[3] || state_d[4] || state_d[5];
			pref_q <= sleep_entry;
			follow_q <= state_d[3];
			dummy_q <= state_d[4] || state_d[5];
			vload_q <= state_d[5];
			rst_out_q <= rst_wake || wdt_rst;
		end
	end

	// Each pin tracks the core until sleep, then keeps drive and enable frozen.
	// The hold spans the start-up wait too, since the core is not running then.
	genvar gi;
	generate
		for (gi = 0; gi < NUM_IO; gi++) begin : g_io
			always_ff @(posedge CLK) begin
				if (RST) begin
					io_q.drv[gi] <= 1'b0;
					io_q.oe[gi] <= 1'b0;
				end else if (!(state_d[1] || state_d[2])) begin
					io_q.drv[gi] <= IO_CORE.drv[gi];
					io_q.oe[gi] <= IO_CORE.oe[gi];
				end
			end
		end
	endgenerate

	// Wishbone slave: one wait state, unmapped addresses read zero and ignore writes.
	always_ff @(posedge CLK) begin
		if (RST) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0;
			ctrl_q <= CTRL_RST_VAL;
		end else begin
			ack_q <= wb_req && !ack_q;
			if (wb_req && !ack_q)
				dat_q <= rd_mux;
			if (wb_wr && hit_ctrl)
				ctrl_q <= WB_REQ.dat[CTRL_W-1:0];
		end
	end

	assign WB_ACK = ack_q;
	assign WB_DAT_O = dat_q;
	assign IO_PINS = io_q;
	assign OSC_DRV_EN = osc_q;
	assign CORE_RUN = run_q;
	assign PREFETCH_NEXT = pref_q;
	assign EXEC_FOLLOW = follow_q;
	assign DUMMY_CYCLE = dummy_q;
	assign VECTOR_LOAD = vload_q;
	assign VECTOR_ADDR = IRQ_VECTOR;
	assign DEVICE_RESET = rst_out_q;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	property p_entry_only;
		$rose(st_sleep) |-> $past(SLEEP_EXEC);
	endproperty
	a_entry_only: assert property (p_entry_only) else $error("sleep entered without instruction");

	property p_entry_flags;
		sleep_entry |=> (!pd_q && to_q && st_sleep);
	endproperty
	a_entry_flags: assert property (p_entry_flags) else $error("flags wrong after entry");

	property p_osc_off;
		st_sleep |-> (!OSC_DRV_EN && !CORE_RUN);
	endproperty
	a_osc_off: assert property (p_osc_off) else $error("oscillator on while asleep");

	property p_io_hold;
		(st_sleep && $past(st_sleep)) |-> $stable(IO_PINS);
	endproperty
	a_io_hold: assert property (p_io_hold) else $error("pins moved while asleep");

	property p_reset_wake;
		rst_wake |=> (DEVICE_RESET && st_run && !EXEC_FOLLOW);
	endproperty
	a_reset_wake: assert property (p_reset_wake) else $error("reset wake not a reset");

	property p_resume;
		(st_sleep && !xtal && (wdt_wake || irq_wake)) |=> (EXEC_FOLLOW && CORE_RUN && !DEVICE_RESET);
	endproperty
	a_resume: assert property (p_resume) else $error("wake did not resume");

	property p_to_clear;
		(wdt_to && !sleep_entry) |=> !to_q;
	endproperty
	a_to_clear: assert property (p_to_clear) else $error("timeout flag not cleared");

	property p_prefetch;
		sleep_entry |=> PREFETCH_NEXT;
	endproperty
	a_prefetch: assert property (p_prefetch) else $error("no prefetch on entry");

	property p_irq_wake;
		irq_wake |=> !st_sleep;
	endproperty
	a_irq_wake: assert property (p_irq_wake) else $error("enabled interrupt did not wake");

	property p_inline;
		(st_resume && !vec_q) |=> (st_run && !DUMMY_CYCLE && !VECTOR_LOAD);
	endproperty
	a_inline: assert property (p_inline) else $error("in-line resume broken");

	property p_vector;
		(EXEC_FOLLOW && vec_q) |=> DUMMY_CYCLE ##1 (DUMMY_CYCLE && VECTOR_LOAD) ##1 (st_run && !DUMMY_CYCLE);
	endproperty
	a_vector: assert property (p_vector) else $error("vector sequence wrong");

	property p_nop;
		(st_run && SLEEP_EXEC && irq_pend) |=> (st_run && $stable(pd_q) && !PREFETCH_NEXT);
	endproperty
	a_nop: assert property (p_nop) else $error("pending interrupt did not make a no-op");

	// The wait is far too long for a delay, so a separate count measures it.
	logic [OST_CNT_W-1:0] ost_seen_q;
	always_ff @(posedge CLK) begin
		if (RST || !st_ost)
			ost_seen_q <= '0;
		else
			ost_seen_q <= ost_seen_q + OST_CNT_W'(1);
	end

	property p_ost;
		$fell(st_ost) |-> (st_resume && ost_seen_q == OST_CNT_W'(OST_CYC));
	endproperty
	a_ost: assert property (p_ost) else $error("start-up wait length wrong");

	property p_ost_stop;
		st_ost |-> (OSC_DRV_EN && !CORE_RUN);
	endproperty
	a_ost_stop: assert property (p_ost_stop) else $error("core ran during start-up wait");

	property p_wdt_reset;
		wdt_rst |=> (DEVICE_RESET && st_run);
	endproperty
	a_wdt_reset: assert property (p_wdt_reset) else $error("running timeout did not reset");

	c_sleep: cover property (sleep_entry);
	c_wdt_wake: cover property (wk_wdt_q && EXEC_FOLLOW);
	c_vector: cover property (VECTOR_LOAD);
	c_nop: cover property (st_run && SLEEP_EXEC && irq_pend);
endmodule

// >>> testbench/swc_core_model.sv
/*
 * Behavioural model of the processor core and its interrupt sources.
 * Assumes the bench calls its tasks from one process, just after a clock edge.
 */
`timescale 1ns/1ps
module swc_core_model (
	input wire logic clk,
	input wire logic core_run,
	input wire logic woke,
	input wire logic noisy,
	input swc_pkg::swc_io_t io_rand,
	output logic sleep_exec,
	output logic wdt_clr_exec,
	output logic global_irq_enable,
	output logic [2:0] irq_flag,
	output swc_pkg::swc_io_t io_core
);
	import swc_pkg::*;
	initial begin
		sleep_exec = 1'b0;
		wdt_clr_exec = 1'b0;
		global_irq_enable = 1'b0;
		irq_flag = 3'h0;
		io_core = '0;
	end
	// A stopped core holds its pin requests; the noise is a fault the bench asks for.
	always @(posedge clk) begin
		if (core_run)
			io_core <= io_rand;
		else if (noisy)
			io_core <= ~io_core;
		if (woke)
			irq_flag <= 3'h0;
	end
	// The word after the power-down instruction is a no-operation, so running it on wake is harmless.
	task automatic pulse_sleep();
		@(posedge clk);
		sleep_exec <= 1'b1;
		@(posedge clk);
		sleep_exec <= 1'b0;
	endtask
	task automatic pulse_clear();
		@(posedge clk);
		wdt_clr_exec <= 1'b1;
		@(posedge clk);
		wdt_clr_exec <= 1'b0;
	endtask
	task automatic set_irq(input logic [2:0] f, input logic g);
		@(posedge clk);
		irq_flag <= f;
		global_irq_enable <= g;
	endtask
endmodule

// >>> testbench/test_sleep_wakeup_control.sv
/*
 * Self-checking bench of the sleep and wake-up controller with a core model.
 * Assumes the controller acks each bus cycle and reports wakes by pulses.
 */
`timescale 1ns/1ps
module test_sleep_wakeup_control;
	import swc_pkg::*;
	localparam int unsigned WD_CYC = 200;
	logic CLK = 1'b0;
	logic RST = 1'b1;
	logic EXT_RESET_REQ = 1'b0;
	logic noisy = 1'b1;
	logic [3:0] wsel = 4'hf;
	swc_wb_req_t WB_REQ = '0;
	swc_io_t io_rand = '0;
	swc_io_t IO_CORE, IO_PINS;
	logic [31:0] WB_DAT_O, ev, v;
	logic [12:0] VECTOR_ADDR;
	logic [2:0] IRQ_FLAG, other;
	logic WB_ACK, SLEEP_EXEC, WDT_CLR_EXEC, GLOBAL_IRQ_ENABLE, OSC_DRV_EN, CORE_RUN;
	logic PREFETCH_NEXT, EXEC_FOLLOW, DUMMY_CYCLE, VECTOR_LOAD, DEVICE_RESET;
	logic [31:0] rd_q[$];
	logic [31:0] ev_q[$];
	int failures = 0;
	int num_checks = 0;
	int dcnt = 0;
	int wcnt = 0;
	int seed = int'(32'he4ad845b);
	always #10 CLK = ~CLK;
	swc_sleep_ctrl #(.WDT_CYC(WD_CYC)) DUT (.CLK, .RST, .WB_REQ, .WB_DAT_O, .WB_ACK, .SLEEP_EXEC, .WDT_CLR_EXEC,
		.EXT_RESET_REQ, .GLOBAL_IRQ_ENABLE, .IRQ_FLAG, .IO_CORE, .IO_PINS, .OSC_DRV_EN, .CORE_RUN,
		.PREFETCH_NEXT, .EXEC_FOLLOW, .DUMMY_CYCLE, .VECTOR_LOAD, .VECTOR_ADDR, .DEVICE_RESET);
	swc_core_model core (.clk(CLK), .core_run(CORE_RUN), .woke(EXEC_FOLLOW), .noisy(noisy), .io_rand(io_rand),
		.sleep_exec(SLEEP_EXEC), .wdt_clr_exec(WDT_CLR_EXEC), .global_irq_enable(GLOBAL_IRQ_ENABLE),
		.irq_flag(IRQ_FLAG), .io_core(IO_CORE));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic conclude();
		$display("Checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
		int i;
		@(posedge CLK);
		WB_REQ <= {1'b1, 1'b1, we, adr, wsel, d};
		for (i = 0; i < 20; i++) begin
			@(posedge CLK);
			if (WB_ACK === 1'b1)
				break;
		end
		if (i == 20) begin
			failures++;
			conclude();
		end else begin
			WB_REQ <= '0;
		end
	endtask
	task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
		rd_q.push_back(exp);
		wb(1'b0, adr, 32'h0);
	endtask
	// Waits until every noted event has shown and the core runs again.
	task automatic settle(input int n);
		int i;
		for (i = 0; i < n; i++) begin
			@(negedge CLK);
			if (ev_q.size() == 0 && CORE_RUN === 1'b1)
				break;
		end
		if (i == n) begin
			failures++;
			conclude();
		end
	endtask
	always @(negedge CLK) begin
		if (RST === 1'b0) begin
			if (DUMMY_CYCLE === 1'b1)
				dcnt++;
			if (OSC_DRV_EN === 1'b1 && CORE_RUN === 1'b0)
				wcnt++;
			if (CORE_RUN === 1'b0)
				chk("pins", {16'h0, io_rand}, {16'h0, IO_PINS});
			if (WB_ACK === 1'b1 && WB_REQ.we === 1'b0)
				chk("read", rd_q.size() > 0 ? rd_q.pop_front() : 32'hxxxxxxxx, WB_DAT_O);
			if ((EXEC_FOLLOW | DEVICE_RESET | VECTOR_LOAD | PREFETCH_NEXT) !== 1'b0) begin
				ev = EXEC_FOLLOW ? {wcnt[23:0], 8'h1} : DEVICE_RESET ? 32'h2 : VECTOR_LOAD ?
					{dcnt[15:0], 3'h0, VECTOR_ADDR} : {28'h0, PREFETCH_NEXT, 1'b0, OSC_DRV_EN, CORE_RUN};
				chk("event", ev_q.size() > 0 ? ev_q.pop_front() : 32'hxxxxxxxx, ev);
				dcnt = 0;
				wcnt = 0;
			end
		end
	end
	initial begin
		int k;
		repeat (20) @(posedge CLK);
		RST <= 1'b0;
		rd(REG_CTRL_ADR, 32'h3);
		rd(REG_STAT_ADR, 32'h3);
		wb(1'b1, 8'hfb, 32'hffffffff);
		rd(8'hfb, 32'h0);
		wb(1'b1, REG_CTRL_ADR, 32'h1c);
		wsel = 4'he;
		wb(1'b1, REG_CTRL_ADR, 32'h03);
		wsel = 4'hf;
		rd(REG_CTRL_ADR, 32'h1c);
		core.set_irq(3'h4, 1'b1);
		core.pulse_sleep();
		repeat (4) @(posedge CLK);
		rd(REG_STAT_ADR, 32'h3);
		for (k = 0; k < 3; k++) begin
			v = $random(seed);
			wb(1'b1, REG_CTRL_ADR, {v[31:5], 5'h0} | (32'h4 << k));
			rd(REG_CTRL_ADR, 32'h4 << k);
			io_rand <= v[15:0];
			noisy <= !k[0];
			other = 3'h1 << ((k + 1) % 3);
			core.set_irq(other, k[0]);
			repeat (4) @(posedge CLK);
			ev_q.push_back(32'h8);
			core.pulse_sleep();
			repeat (20) @(posedge CLK);
			if (k == 0)
				rd(REG_STAT_ADR, 32'h6);
			ev_q.push_back(32'h1);
			if (k[0])
				ev_q.push_back({16'd2, 3'h0, IRQ_VECTOR});
			core.set_irq(other | (3'h1 << k), k[0]);
			settle(100);
			rd(REG_STAT_ADR, 32'h12);
		end
		wb(1'b1, REG_CTRL_ADR, 32'h06);
		ev_q.push_back(32'h8);
		core.pulse_sleep();
		repeat (10) @(posedge CLK);
		ev_q.push_back({24'(OST_CYC), 8'h1});
		core.set_irq(3'h1, 1'b0);
		settle(1200);
		wb(1'b1, REG_CTRL_ADR, 32'h01);
		repeat (3) begin
			core.pulse_clear();
			repeat (150) @(posedge CLK);
		end
		ev_q.push_back(32'h8);
		ev_q.push_back(32'h1);
		core.pulse_sleep();
		settle(400);
		rd(REG_STAT_ADR, 32'h08);
		ev_q.push_back(32'h2);
		settle(400);
		wb(1'b1, REG_CTRL_ADR, 32'h00);
		ev_q.push_back(32'h8);
		core.pulse_sleep();
		repeat (10) @(posedge CLK);
		ev_q.push_back(32'h2);
		EXT_RESET_REQ <= 1'b1;
		@(posedge CLK);
		EXT_RESET_REQ <= 1'b0;
		settle(50);
		conclude();
	end
endmodule
